// File: hw/mma_defs.svh
// constant definitions shared by the memory attribute and atomicity policy block
// Overview of operation
// [RULE_01] No exclusive load or store support; no exclusive monitor exists.
// [RULE_02] Each access carries exactly one type: Normal, Device or Strongly-ordered.
// [RULE_03] Strongly-ordered accesses stay in program order and are always shareable.
// [RULE_04] Device has shareability only; Normal adds non-, write-through or write-back caching.
// [RULE_05] Normal cacheability is handled independently of shareability.
// [RULE_06] Bytes, aligned halfwords and aligned words are single-copy atomic.
// [RULE_07] Multi-word transfers go out as aligned 32-bit transfers, each atomic.
// [RULE_08] Non-atomic accesses are split into atomic pieces, bytes at the coarsest.
// [RULE_09] Instruction fetches are atomic in 16-bit units.
// [RULE_10] Line fills and evictions never change atomicity of data or fetches.
// [RULE_11] Atomic writes to Device or Strongly-ordered memory are multi-copy atomic.
// [RULE_12] Writes to one location serialize; Normal writes repeat only until overwritten.
// [RULE_13] Normal writes need not be multi-copy atomic and may be merged.
// [RULE_14] Normal accesses may repeat reads, prefetch, merge and go unaligned.
// [RULE_15] An interrupted multi-transfer may be abandoned and later restarted whole.
// [RULE_16] Non-shareable Normal caches need not be transparent; software keeps coherency.
// [RULE_17] Shareable Normal caches must be transparent to data accesses.
// [RULE_18] Shareable regions may simply never be cached.
// [RULE_19] Requests carry type, shareability, cacheability, size, address; issue whole or split.
// [RULE_20] Merge, repeat and prefetch only for Normal; never for Device or Strongly-ordered.
`ifndef MMA_DEFS_SVH
`define MMA_DEFS_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define MMA_ADDR_W      32
`define MMA_DATA_W      32
`define MMA_OFFS_W      3

// ----------------------------------------------------------------------
// encodings
// ----------------------------------------------------------------------
`define MMA_MT_NORMAL   2'h0
`define MMA_MT_DEVICE   2'h1
`define MMA_MT_STRONG   2'h2
`define MMA_CA_NONE     2'h0
`define MMA_CA_WTHRU    2'h1
`define MMA_CA_WBACK    2'h2
`define MMA_SZ_BYTE     2'h0
`define MMA_SZ_HALF     2'h1
`define MMA_SZ_WORD     2'h2
`define MMA_ST_IDLE     3'h1
`define MMA_ST_ISSUE    3'h2
`define MMA_ST_WAIT     3'h4

// ----------------------------------------------------------------------
// lane arithmetic
// ----------------------------------------------------------------------
`define MMA_ONE_BYTE    3'h1
`define MMA_LANE0       2'h0
`define MMA_OFFS_ZERO   3'h0
`define MMA_BIT_PAD     3'h0
`define MMA_MASK_BYTE   32'h000000ff
`define MMA_MASK_HALF   32'h0000ffff
`define MMA_MASK_WORD   32'hffffffff

`endif

// File: hw/mma_pkg.sv
// types and decode helpers of the memory attribute and atomicity policy block
`include "mma_defs.svh"

package mma_pkg;

  // --------------------------------------------------------------------
  // attribute and state enumerations
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    MEM_NORMAL = `MMA_MT_NORMAL,
    MEM_DEVICE = `MMA_MT_DEVICE,
    MEM_STRONG = `MMA_MT_STRONG
  } mma_memtype_t;

  typedef enum logic [1:0] {
    CACHE_NONE  = `MMA_CA_NONE,
    CACHE_WTHRU = `MMA_CA_WTHRU,
    CACHE_WBACK = `MMA_CA_WBACK
  } mma_cache_t;

  typedef enum logic [2:0] {
    ST_IDLE  = `MMA_ST_IDLE,
    ST_ISSUE = `MMA_ST_ISSUE,
    ST_WAIT  = `MMA_ST_WAIT
  } mma_state_t;

  // --------------------------------------------------------------------
  // request from the core and transfer to the system bus
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [`MMA_ADDR_W-1:0] addr;
    logic [1:0]             size;
    logic                   write;
    logic [`MMA_DATA_W-1:0] wdata;
    logic                   fetch;
    logic                   multi;
    mma_memtype_t           memType;
    logic                   shareable;
    mma_cache_t             cache;
  } mma_req_t;

  typedef struct packed {
    logic [`MMA_ADDR_W-1:0] addr;
    logic [1:0]             size;
    logic                   write;
    logic [`MMA_DATA_W-1:0] wdata;
    logic                   fetch;
    mma_memtype_t           memType;
    logic                   shareable;
    logic                   strictOrder;
    logic                   cacheAlloc;
    logic                   posted;
    logic                   mergeOk;
    logic                   prefetchOk;
    logic                   repeatOk;
  } mma_xfer_t;

  // --------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------
  function automatic logic [2:0] size_bytes(input logic [1:0] size);
    return `MMA_ONE_BYTE << size;
  endfunction : size_bytes

  // natural alignment is what makes a piece single-copy atomic
  function automatic logic is_aligned(input logic [1:0] lane, input logic [1:0] size);
    logic ok;
    case (size)
      `MMA_SZ_BYTE: ok = 1'b1;
      `MMA_SZ_HALF: ok = ~lane[0];
      default:      ok = (lane == `MMA_LANE0);
    endcase
    return ok;
  endfunction : is_aligned

  function automatic logic [`MMA_DATA_W-1:0] byte_mask(input logic [1:0] size);
    logic [`MMA_DATA_W-1:0] m;
    case (size)
      `MMA_SZ_BYTE: m = `MMA_MASK_BYTE;
      `MMA_SZ_HALF: m = `MMA_MASK_HALF;
      default:      m = `MMA_MASK_WORD;
    endcase
    return m;
  endfunction : byte_mask

endpackage : mma_pkg

// File: hw/mma_piece_calc.sv
// piece splitter: size and address of the next single-copy-atomic piece
`timescale 1ns/1ps
`include "mma_defs.svh"

module mma_piece_calc (
  input  wire logic [`MMA_ADDR_W-1:0] baseAddr,
  input  wire logic [1:0]             size,
  input  wire logic                   fetch,
  input  wire logic [`MMA_OFFS_W-1:0] offset,
  output logic      [`MMA_ADDR_W-1:0] pieceAddr,
  output logic      [1:0]             pieceSize,
  output logic                        lastPiece
);

  // ----------------------------------------------------------------------
  // piece selection
  // ----------------------------------------------------------------------
  logic wholeAtomic;
  logic [3:0] reach;

  // whole access only when naturally aligned; a word fetch still goes out as halfwords
  always_comb begin
    wholeAtomic = mma_pkg::is_aligned(baseAddr[1:0], size)
                  && !(fetch && size == `MMA_SZ_WORD);              // [RULE_06] [RULE_09]
    if (wholeAtomic) begin
      pieceSize = size;                                             // [RULE_19]
    end else if (fetch) begin
      pieceSize = `MMA_SZ_HALF;                                     // [RULE_09]
    end else begin
      pieceSize = `MMA_SZ_BYTE;                                     // [RULE_08]
    end
    pieceAddr = baseAddr + `MMA_ADDR_W'(offset);
    reach     = 4'(offset) + 4'(mma_pkg::size_bytes(pieceSize));
    lastPiece = (reach >= 4'(mma_pkg::size_bytes(size)));
  end

endmodule : mma_piece_calc

// File: hw/mma_policy.sv
// memory attribute and atomicity policy between core load-store/fetch and system bus
`timescale 1ns/1ps
`include "mma_defs.svh"

module mma_policy (
  input  wire logic                   core_clk,
  input  wire logic                   reset_n,
  input  wire logic                   reqValid,
  output logic                        reqReady,
  input  wire mma_pkg::mma_req_t      req,
  input  wire logic                   abortReq,
  output logic                        rspValid,
  output logic      [`MMA_DATA_W-1:0] rspData,
  output logic                        rspAborted,
  output logic                        busValid,
  input  wire logic                   busReady,
  output mma_pkg::mma_xfer_t          busXfer,
  input  wire logic                   busDone,
  input  wire logic [`MMA_DATA_W-1:0] busRdata,
  input  wire logic                   snoopValid,
  input  wire logic [`MMA_ADDR_W-1:0] snoopAddr
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // there is no exclusive monitor: requests have no exclusive flavour at all  [RULE_01]
  function automatic mma_pkg::mma_req_t normalize(input mma_pkg::mma_req_t r);
    mma_pkg::mma_req_t n;
    n = r;
    case (r.memType)
      mma_pkg::MEM_NORMAL: n.cache = r.cache;                         // [RULE_04] [RULE_05]
      mma_pkg::MEM_DEVICE: n.cache = mma_pkg::CACHE_NONE;             // [RULE_04]
      default: begin
        n.memType   = mma_pkg::MEM_STRONG;                            // [RULE_02]
        n.shareable = 1'b1;                                           // [RULE_03]
        n.cache     = mma_pkg::CACHE_NONE;
      end
    endcase
    if (r.multi) begin
      n.size      = `MMA_SZ_WORD;                                     // [RULE_07]
      n.addr[1:0] = `MMA_LANE0;
    end
    return n;
  endfunction : normalize

  // attribute policy of one piece; shared data is never allocated, which keeps caches
  // transparent without a coherency scheme
  function automatic mma_pkg::mma_xfer_t build_xfer(input mma_pkg::mma_req_t c,
                                                     input logic [`MMA_ADDR_W-1:0] pAddr,
                                                     input logic [1:0] pSize,
                                                     input logic [`MMA_OFFS_W-1:0] offs);
    mma_pkg::mma_xfer_t x;
    logic normal;
    normal        = (c.memType == mma_pkg::MEM_NORMAL);
    x.addr        = pAddr;
    x.size        = pSize;
    x.write       = c.write;
    x.wdata       = (c.wdata >> {offs, `MMA_BIT_PAD}) << {pAddr[1:0], `MMA_BIT_PAD};
    x.fetch       = c.fetch;
    x.memType     = c.memType;
    x.shareable   = c.shareable;
    x.strictOrder = (c.memType == mma_pkg::MEM_STRONG);               // [RULE_03]
    x.cacheAlloc  = normal && (c.cache != mma_pkg::CACHE_NONE)
                    && !c.shareable;                                  // [RULE_16] [RULE_17] [RULE_18]
    x.posted      = normal && c.write && !c.fetch;                    // [RULE_11] [RULE_13]
    x.mergeOk     = normal;                                           // [RULE_13] [RULE_20]
    x.prefetchOk  = normal && !c.write;                               // [RULE_14] [RULE_20]
    x.repeatOk    = normal;                                           // [RULE_14] [RULE_20]
    return x;
  endfunction : build_xfer

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  mma_pkg::mma_state_t        state;
  mma_pkg::mma_state_t        next_state;
  mma_pkg::mma_req_t          cur;
  mma_pkg::mma_req_t          next_cur;
  logic [`MMA_OFFS_W-1:0]     offset;
  logic [`MMA_OFFS_W-1:0]     next_offset;
  logic                       curLast;
  logic                       next_curLast;
  logic                       abortPend;
  logic                       next_abortPend;
  logic                       rspSent;
  logic                       next_rspSent;
  logic                       next_reqReady;
  logic                       next_rspValid;
  logic [`MMA_DATA_W-1:0]     next_rspData;
  logic                       next_rspAborted;
  logic                       next_busValid;
  mma_pkg::mma_xfer_t         next_busXfer;
  logic                       issueNew;
  logic                       advance;
  logic                       stopNow;
  logic [`MMA_ADDR_W-1:0]     calcAddr;
  logic [1:0]                 calcSize;
  logic                       calcLast;

  // ----------------------------------------------------------------------
  // request capture and piece offset
  // ----------------------------------------------------------------------
  // kept apart from the main next-state logic so the splitter sees no feedback path
  always_comb begin
    stopNow  = abortPend || abortReq;
    issueNew = (state == mma_pkg::ST_IDLE) && reqValid && reqReady;
    advance  = (state == mma_pkg::ST_WAIT) && busDone && !curLast && !stopNow;
    next_cur = issueNew ? normalize(req) : cur;                       // [RULE_19]
    if (issueNew) begin
      next_offset = `MMA_OFFS_ZERO;
    end else if (advance) begin
      next_offset = `MMA_OFFS_W'(offset + mma_pkg::size_bytes(busXfer.size)); // [RULE_08]
    end else begin
      next_offset = offset;
    end
  end

  mma_piece_calc u_piece (
    .baseAddr  (next_cur.addr),
    .size      (next_cur.size),
    .fetch     (next_cur.fetch),
    .offset    (next_offset),
    .pieceAddr (calcAddr),
    .pieceSize (calcSize),
    .lastPiece (calcLast)
  );

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  // one piece outstanding at a time: every access completes before the next leaves,
  // which gives program order for all types at the cost of bus throughput
  always_comb begin
    next_state      = state;
    next_curLast    = curLast;
    next_abortPend  = abortPend || (abortReq && state != mma_pkg::ST_IDLE); // [RULE_15]
    next_rspSent    = rspSent;
    next_reqReady   = reqReady;
    next_rspValid   = 1'b0;
    next_rspData    = rspData;
    next_rspAborted = rspAborted;
    next_busValid   = busValid;
    next_busXfer    = busXfer;
    case (state)
      mma_pkg::ST_IDLE: begin
        if (issueNew) begin
          next_busXfer   = build_xfer(next_cur, calcAddr, calcSize, next_offset);
          next_busValid  = 1'b1;
          next_curLast   = calcLast;
          next_reqReady  = 1'b0;
          next_rspData   = '0;
          next_rspSent   = 1'b0;
          next_abortPend = 1'b0;
          next_state     = mma_pkg::ST_ISSUE;
        end
      end
      mma_pkg::ST_ISSUE: begin
        if (busReady) begin
          next_busValid = 1'b0;
          next_state    = mma_pkg::ST_WAIT;
          // normal writes are acknowledged on acceptance; others wait for completion
          if (curLast && busXfer.posted) begin                        // [RULE_13]
            next_rspValid   = 1'b1;
            next_rspAborted = 1'b0;
            next_rspSent    = 1'b1;
          end
        end else if (abortPend) begin
          next_busValid   = 1'b0;                                     // [RULE_15]
          next_rspValid   = 1'b1;
          next_rspAborted = 1'b1;
          next_reqReady   = 1'b1;
          next_state      = mma_pkg::ST_IDLE;
        end
      end
      mma_pkg::ST_WAIT: begin
        if (busDone) begin
          if (!busXfer.write) begin
            next_rspData = rspData | (((busRdata >> {busXfer.addr[1:0], `MMA_BIT_PAD})
                           & mma_pkg::byte_mask(busXfer.size)) << {offset, `MMA_BIT_PAD});
          end
          if (curLast) begin
            next_rspValid   = !rspSent;                               // [RULE_11]
            next_rspAborted = rspSent ? rspAborted : 1'b0;
            next_reqReady   = 1'b1;
            next_state      = mma_pkg::ST_IDLE;
          end else if (stopNow) begin
            // remaining pieces are dropped; the core restarts the whole instruction
            next_rspValid   = 1'b1;                                   // [RULE_15]
            next_rspAborted = 1'b1;
            next_reqReady   = 1'b1;
            next_state      = mma_pkg::ST_IDLE;
          end else begin
            next_busXfer  = build_xfer(next_cur, calcAddr, calcSize, next_offset); // [RULE_07]
            next_busValid = 1'b1;
            next_curLast  = calcLast;
            next_state    = mma_pkg::ST_ISSUE;
          end
        end
      end
      default: begin
        next_busValid = 1'b0;
        next_reqReady = 1'b1;
        next_state    = mma_pkg::ST_IDLE;
      end
    endcase
    // a foreign write to the same address ends the freedom to repeat; the clear beats build
    if (snoopValid && snoopAddr == next_busXfer.addr) begin
      next_busXfer.repeatOk = 1'b0;                                   // [RULE_12]
    end
  end

  // register stage; cache fills never touch these pieces, so atomicity is unaffected
  always_ff @(posedge core_clk or negedge reset_n) begin               // [RULE_10]
    if (!reset_n) begin
      state      <= mma_pkg::ST_IDLE;
      cur        <= '0;
      offset     <= `MMA_OFFS_ZERO;
      curLast    <= 1'b0;
      abortPend  <= 1'b0;
      rspSent    <= 1'b0;
      reqReady   <= 1'b1;
      rspValid   <= 1'b0;
      rspData    <= '0;
      rspAborted <= 1'b0;
      busValid   <= 1'b0;
      busXfer    <= '0;
    end else begin
      state      <= next_state;
      cur        <= next_cur;
      offset     <= next_offset;
      curLast    <= next_curLast;
      abortPend  <= next_abortPend;
      rspSent    <= next_rspSent;
      reqReady   <= next_reqReady;
      rspValid   <= next_rspValid;
      rspData    <= next_rspData;
      rspAborted <= next_rspAborted;
      busValid   <= next_busValid;
      busXfer    <= next_busXfer;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  property p_strict_shared;
    busValid && busXfer.strictOrder |-> busXfer.shareable;
  endproperty
  a_strict_shared: assert property (p_strict_shared) // [RULE_03]
    else $error("strongly ordered transfer not marked shareable");

  property p_no_spec_device;
    busValid && busXfer.memType != mma_pkg::MEM_NORMAL |->
      !(busXfer.mergeOk || busXfer.prefetchOk || busXfer.repeatOk || busXfer.posted);
  endproperty
  a_no_spec_device: assert property (p_no_spec_device) // [RULE_20]
    else $error("non-normal transfer allows merge, prefetch, repeat or posting");

  property p_shared_uncached;
    busValid && (busXfer.shareable || busXfer.memType != mma_pkg::MEM_NORMAL)
      |-> !busXfer.cacheAlloc;
  endproperty
  a_shared_uncached: assert property (p_shared_uncached) // [RULE_18]
    else $error("shareable or non-normal transfer allocates in cache");

  property p_piece_atomic;
    busValid |-> mma_pkg::is_aligned(busXfer.addr[1:0], busXfer.size);
  endproperty
  a_piece_atomic: assert property (p_piece_atomic) // [RULE_06]
    else $error("transfer piece is not naturally aligned");

  property p_split_bytes;
    busValid && !cur.fetch && !mma_pkg::is_aligned(cur.addr[1:0], cur.size)
      |-> busXfer.size == `MMA_SZ_BYTE;
  endproperty
  a_split_bytes: assert property (p_split_bytes) // [RULE_08]
    else $error("unaligned data access not split into bytes");

  property p_fetch_half;
    busValid && busXfer.fetch |-> busXfer.size == `MMA_SZ_HALF
      || (busXfer.size == `MMA_SZ_BYTE && cur.size == `MMA_SZ_BYTE);
  endproperty
  a_fetch_half: assert property (p_fetch_half) // [RULE_09]
    else $error("fetch piece is not a halfword");

  property p_multi_word;
    busValid && cur.multi |-> busXfer.size == `MMA_SZ_WORD && busXfer.addr[1:0] == `MMA_LANE0;
  endproperty
  a_multi_word: assert property (p_multi_word) // [RULE_07]
    else $error("multi-word transfer not an aligned word");

  property p_nonposted;
    state == mma_pkg::ST_WAIT && busDone && curLast && !busXfer.posted
      |=> rspValid && !rspAborted && reqReady;
  endproperty
  a_nonposted: assert property (p_nonposted) // [RULE_11]
    else $error("completion of non-posted access not answered next cycle");

  property p_hold;
    busValid && !busReady && !abortPend |=>
      busValid && $stable(busXfer.addr) && $stable(busXfer.size) && $stable(busXfer.wdata);
  endproperty
  a_hold: assert property (p_hold) // [RULE_03]
    else $error("pending transfer changed or withdrawn");

  property p_abort;
    state == mma_pkg::ST_ISSUE && !busReady && abortPend |=>
      rspValid && rspAborted && reqReady && !busValid;
  endproperty
  a_abort: assert property (p_abort) // [RULE_15]
    else $error("abandoned sequence not ended next cycle");

  c_unaligned_read: cover property (issueNew && !req.write && req.size == `MMA_SZ_WORD
                                    && req.addr[1:0] != `MMA_LANE0 ##[1:40] rspValid);
  c_strict_write: cover property (busValid && busReady && busXfer.strictOrder && busXfer.write);
  c_abort: cover property (rspValid && rspAborted);
  c_fetch_split: cover property (busValid && busXfer.fetch && !curLast);

endmodule : mma_policy

// File: testbench/mma_bus_model.sv
// system bus partner: byte memory answering one piece at a time
`timescale 1ns/1ps
module mma_bus_model (
  input  wire logic               core_clk,
  input  wire logic               busValid,
  input  wire mma_pkg::mma_xfer_t busXfer,
  input  wire logic               slow,
  output logic                    busReady,
  output logic                    busDone,
  output logic [31:0]             busRdata
);
  logic [7:0] mem [256];
  logic [7:0] pa;
  logic       pend;
  logic [1:0] dly;
  initial begin
    foreach (mem[i]) mem[i] = 8'(i * 7 + 3);
    {busReady, busDone, busRdata, pend, dly, pa} = '0;
  end
  // writes land in acceptance order, so one location sees one write order
  always @(posedge core_clk) begin
    busDone  <= 1'b0;
    busRdata <= ~busRdata; // released data keeps changing
    if (busValid && busReady) begin
      busReady <= 1'b0;
      pend     <= 1'b1;
      pa       <= {busXfer.addr[7:2], 2'h0};
      dly      <= slow ? 2'h3 : 2'h0;
      for (int k = 0; k < 4; k++)
        if (busXfer.write && k >= busXfer.addr[1:0] && k < busXfer.addr[1:0] + (1 << busXfer.size))
          mem[{busXfer.addr[7:2], 2'(k)}] <= busXfer.wdata[8*k +: 8];
    end else if (pend) begin
      if (dly == 2'h0) begin
        pend     <= 1'b0;
        busDone  <= 1'b1;
        busRdata <= {mem[pa+8'h3], mem[pa+8'h2], mem[pa+8'h1], mem[pa]};
      end else dly <= dly - 2'h1;
    end else busReady <= busValid && (!slow || $urandom_range(1, 0) == 1);
  end
endmodule : mma_bus_model

// File: testbench/testbench.sv
// self-checking bench of the memory attribute and atomicity policy block
`timescale 1ns/1ps
module testbench;
  logic core_clk, reset_n, reqValid, reqReady, abortReq, rspValid, rspAborted;
  logic busValid, busReady, busDone, slow, curSh, curWr, curSn, snoopValid;
  logic [31:0] rspData, busRdata, snoopAddr;
  logic [1:0] curMt, curCa;
  logic [7:0] shadow [256];
  mma_pkg::mma_req_t  req;
  mma_pkg::mma_xfer_t busXfer;
  int errTotal, numChecks, pieces;
  wire nrm = curMt == 2'h0;
  wire so  = curMt == 2'h2;
  mma_policy dut (.core_clk(core_clk), .reset_n(reset_n), .reqValid(reqValid),
    .reqReady(reqReady), .req(req), .abortReq(abortReq), .rspValid(rspValid),
    .rspData(rspData), .rspAborted(rspAborted), .busValid(busValid), .busReady(busReady),
    .busXfer(busXfer), .busDone(busDone), .busRdata(busRdata), .snoopValid(snoopValid),
    .snoopAddr(snoopAddr));
  mma_bus_model bus (.core_clk(core_clk), .busValid(busValid), .busXfer(busXfer),
    .slow(slow), .busReady(busReady), .busDone(busDone), .busRdata(busRdata));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic printVerdict();
    $display("checks %0d errors %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : printVerdict
  function automatic int expPieces(logic [7:0] a, logic [1:0] sz, logic ft, logic mu);
    if (mu) return 1;
    if (sz == 2'h2 && a[1:0] == 2'h0) return ft ? 2 : 1;
    if (sz == 2'h0 || (sz == 2'h1 && !a[0])) return 1;
    return 1 << sz;
  endfunction : expPieces
  // every accepted piece is naturally aligned and carries its region's policy
  always @(posedge core_clk) if (busValid && busReady) begin
    pieces++;
    check(32'({1'b0, busXfer.addr[1:0]} & ((3'h1 << busXfer.size) - 3'h1)), 32'h0);
    // a snoop on the first piece's address ends its freedom to repeat
    check(32'({busXfer.write, busXfer.posted, busXfer.mergeOk,
      busXfer.repeatOk, busXfer.prefetchOk}), 32'({curWr, nrm & curWr, nrm,
      nrm & !(curSn && pieces == 1), nrm & !curWr}));
    check(32'({busXfer.strictOrder, busXfer.shareable,
      busXfer.memType}), 32'({so, curSh | so, curMt}));
    check(32'(busXfer.cacheAlloc), 32'(nrm & !curSh & (curCa != 2'h0)));
    if (busXfer.fetch) check(32'(busXfer.size), 32'h1);
  end
  // one core request; waits are bounded and a hang closes the run
  task automatic access(input logic [7:0] a, input logic [1:0] sz,
      input logic wr, input logic ft, input logic mu, input logic ab, input logic [31:0] wd);
    int n;
    int i;
    logic [31:0] m;
    logic abx;
    n = expPieces(a, sz, ft, mu);
    m = 32'hffffffff >> (32 - (8 << sz));
    i = 0;
    while (reqReady !== 1'b1 && i < 500) begin @(posedge core_clk); #1; i++; end
    @(posedge core_clk);
    curWr = wr;
    pieces = 0;
    req <= '{addr: 32'(a), size: sz, write: wr, wdata: wd, fetch: ft, multi: mu,
      memType: mma_pkg::mma_memtype_t'(curMt), shareable: curSh,
      cache: mma_pkg::mma_cache_t'(curCa)};
    reqValid <= 1'b1;
    snoopValid <= curSn;
    snoopAddr <= 32'(a);
    @(posedge core_clk);
    reqValid <= 1'b0;
    snoopValid <= 1'b0;
    abortReq <= ab;
    do begin @(posedge core_clk); #1; i++; end while (rspValid !== 1'b1 && i < 1000);
    abortReq = 1'b0;
    if (rspValid !== 1'b1) begin errTotal++; printVerdict(); end
    // a lone piece not yet accepted when the abort lands is dropped as well
    abx = ab && (n > 1 || pieces == 0);
    check(32'(rspAborted), 32'(abx));
    if (!abx) check(pieces, n);
    if (!wr && !abx)
      check(rspData & m, {shadow[a+8'h3], shadow[a+8'h2], shadow[a+8'h1], shadow[a]} & m);
    for (i = 0; i < (1 << sz); i++) if (wr) shadow[a+8'(i)] = wd[8*i +: 8];
  endtask : access
  initial begin
    logic [7:0] a;
    logic [1:0] sz;
    logic ft, mu, wr;
    {reset_n, reqValid, abortReq, slow, curSh, curWr, curMt, curCa, curSn, snoopValid} = '0;
    snoopAddr = '0;
    req = '0;
    {errTotal, numChecks, pieces} = '0;
    foreach (shadow[i]) shadow[i] = 8'(i * 7 + 3);
    void'($urandom(32'h56b5));
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    // corners: unaligned split, abort mid-sequence, abort on a lone piece, fetch
    access(8'h01, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0, 32'ha1b2c3d4);
    access(8'h01, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
    slow = 1'b1;
    access(8'h05, 2'h2, 1'b0, 1'b0, 1'b0, 1'b1, 32'h0);
    access(8'h08, 2'h2, 1'b0, 1'b0, 1'b0, 1'b1, 32'h0);
    curMt = 2'h2;
    access(8'h0c, 2'h2, 1'b0, 1'b1, 1'b0, 1'b0, 32'h0);
    repeat (80) begin
      curMt = 2'($urandom_range(2, 0));
      curSh = 1'($urandom_range(1, 0));
      curCa = 2'($urandom_range(2, 0));
      slow = 1'($urandom_range(1, 0));
      curSn = 1'($urandom_range(1, 0));
      sz = 2'($urandom_range(2, 0));
      a = 8'($urandom_range(60, 0));
      ft = $urandom_range(3, 0) == 0;
      mu = !ft && $urandom_range(3, 0) == 0;
      wr = !ft && $urandom_range(1, 0) == 1;
      if (ft && sz == 2'h0) sz = 2'h1;
      if (mu) sz = 2'h2;
      if (ft || mu || curMt != 2'h0) a = a & ~((8'h1 << sz) - 8'h1); // no unaligned device access
      access(a, sz, wr, ft, mu, 1'b0, $urandom());
    end
    printVerdict();
  end
endmodule : testbench
